// File: hw/fomc_map.svh
// Command codes, addresses, reset values and CRC constants for overlay control.
`ifndef FOMC_MAP_SVH
`define FOMC_MAP_SVH
// ----------------------------------------------------------------
// Bus widths.
// ----------------------------------------------------------------
`define FOMC_AW 25
`define FOMC_DW 16
// ----------------------------------------------------------------
// Command data codes.
// ----------------------------------------------------------------
`define FOMC_ID_ADDR 25'h000_0555
`define FOMC_CMD_ID 16'h0098
`define FOMC_CMD_EXIT 16'h00F0
`define FOMC_CMD_STAT 16'h0070
`define FOMC_CMD_SSR 16'h0088
`define FOMC_CMD_LEGEXIT 16'h0090
`define FOMC_CMD_CFG 16'h0040
`define FOMC_CMD_PWD 16'h0060
`define FOMC_CMD_PPB 16'h00C0
`define FOMC_CMD_LOCK 16'h0050
`define FOMC_CMD_DYB 16'h00E0
`define FOMC_CMD_ECC 16'h0075
`define FOMC_CMD_CRC 16'h0078
`define FOMC_CMD_PROG 16'h00A0
`define FOMC_CMD_WBUF 16'h0025
`define FOMC_CMD_UNLOCK 16'h0028
`define FOMC_CMD_PPBERASE 16'h0030
`define FOMC_CMD_CRCBEG 16'h00C1
`define FOMC_CMD_CRCEND 16'h00C2
`define FOMC_CMD_SUSP 16'h00B0
`define FOMC_CMD_RESUME 16'h0030
`define FOMC_CMD_ECCSTAT 16'h0064
`define FOMC_CMD_TRAPLO 16'h0061
`define FOMC_CMD_TRAPHI 16'h0062
`define FOMC_CMD_ECCCNT 16'h0063
// ----------------------------------------------------------------
// Overlay addresses and reset values.
// ----------------------------------------------------------------
`define FOMC_CFG_ADDR 25'h000_0000
`define FOMC_PWD_LAST 25'h000_0003
`define FOMC_CFG_RST 16'hFFFF
`define FOMC_LOCK_RST 1'h1
`define FOMC_CRC_POLY 32'h04C1_1DB7
`define FOMC_CRC_INIT 32'hFFFF_FFFF
`endif

// File: hw/fomc_pkg.sv
// Types shared by the overlay control: modes and bus carriers.
`default_nettype none
`include "fomc_map.svh"
package fomc_pkg;
  // Active address map.
  typedef enum logic [3:0] {
    FOMC_RD = 4'h0, FOMC_ID = 4'h1, FOMC_STAT = 4'h2, FOMC_SSR = 4'h3,
    FOMC_CFG = 4'h4, FOMC_PWD = 4'h5, FOMC_PPB = 4'h6, FOMC_LOCK = 4'h7,
    FOMC_DYB = 4'h8, FOMC_ECC = 4'h9, FOMC_CRC = 4'hA
  } fomc_mode_e;
  // One command or data write from the host.
  typedef struct packed {
    logic [`FOMC_AW-1:0] addr;
    logic [`FOMC_DW-1:0] data;
  } fomc_wr_s;
  // One read beat from the host.
  typedef struct packed {
    logic [`FOMC_AW-1:0] addr;
    logic first;
  } fomc_rd_s;
endpackage
`default_nettype wire

// File: hw/fomc_overlay_ctrl.sv
// Overlay mode command interpreter with protection bits and CRC engine.
//
// Overview of operation
// - CRC result split in low/high halves
// - CRC over start to end inclusive
// - ID overlay entry only at word 0x555, so it covers sector 0
// - Status command captures; first read restores map
// - Status only on first burst beat
// - Secure sector outside region reads zero
// - Other sectors read array, no exit
// - Secure programming; legacy or common exit
// - Config register at word 0 only
// - Config register programmable by program command
// - Password at words 0-3, programmable
// - Password unlock clears global lock bit
// - Persistent bit in bit 0, settable
// - Erase clears all persistent bits
// - Lock bit in bit 0, program clears
// - Volatile bit in bit 0, set/clear
// - Protection overlays exit legacy or common
// - ECC status bits 4:0 per half-page
// - Trap and counter registers readable
// - Running CRC overlays array; suspend reveals
// - Suspended CRC accepts only array reads
// - CRC load, suspend, resume, read, exit
// - Reset command returns to read mode
`default_nettype none
`include "fomc_map.svh"
module fomc_overlay_ctrl #(
  parameter int SOFF = 17,
  parameter int HPB = 4,
  parameter int SSR_WORDS = 512
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic wr_valid,
  input wire fomc_pkg::fomc_wr_s wr,
  input wire logic rd_req,
  input wire fomc_pkg::fomc_rd_s rd,
  output logic rd_valid,
  output logic [`FOMC_DW-1:0] rd_data,
  output logic [`FOMC_AW-1:0] array_addr,
  input wire logic [`FOMC_DW-1:0] array_rdata,
  input wire logic [`FOMC_DW-1:0] status_in,
  output logic [SOFF-1:0] aux_addr,
  output logic aux_sel_id,
  input wire logic [`FOMC_DW-1:0] aux_rdata,
  output logic aux_wr,
  output logic [SOFF-1:0] aux_waddr,
  output logic [`FOMC_DW-1:0] aux_wdata,
  output logic [`FOMC_AW-HPB-1:0] ecc_hp_addr,
  input wire logic [4:0] ecc_status,
  input wire logic [`FOMC_DW-1:0] ecc_trap_lo,
  input wire logic [`FOMC_DW-1:0] ecc_trap_hi,
  input wire logic [`FOMC_DW-1:0] ecc_count,
  output logic [15:0] crc_result_low,
  output logic [15:0] crc_result_high,
  output logic crc_busy,
  output var fomc_pkg::fomc_mode_e mode
);
  import fomc_pkg::*;

  localparam int AW = `FOMC_AW;
  localparam int SW = AW - SOFF;
  localparam int NSEC = 2 ** SW;

  // ----------------------------------------------------------------
  // Helper functions.
  // ----------------------------------------------------------------
  // Sector number of a word address.
  function automatic logic [SW-1:0] sec(input logic [AW-1:0] a);
    return a[AW-1:SOFF];
  endfunction

  // One 16-bit word folded into the running check-value, MSB first.
  function automatic logic [31:0] crc_step(input logic [31:0] c,
                                           input logic [15:0] w);
    logic [31:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = (r[31] ^ w[i]) ? ((r << 1) ^ `FOMC_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  fomc_mode_e ret_mode; // Map to restore after a status read.
  logic [SW-1:0] ovl_sec; // Sector chosen on overlay entry.
  logic [15:0] status_cap; // Status captured by the status command.
  logic stat_tail; // Rest of the burst that carried status.
  logic prog_pend; // Next write is program data.
  logic wbuf_arm; // Next write is the buffer word count.
  logic [8:0] wbuf_cnt; // Buffered words still to come.
  logic [2:0] unl_cnt; // Unlock password words still to come.
  logic unl_ok; // All unlock words so far matched.
  logic [15:0] cfg_reg; // Protection configuration register.
  logic [15:0] pwd [4]; // Password words.
  logic [NSEC-1:0] persistent_sector_protect_bit; // Persistent per-sector protect bits.
  logic [NSEC-1:0] volatile_sector_protect_bit; // Volatile per-sector protect bits.
  logic lock; // Global protect lock bit.
  logic [1:0] ecc_sel; // ECC overlay read selection.
  logic crc_susp; // CRC calculation suspended.
  logic [AW-1:0] crc_beg; // Loaded beginning address.
  logic [AW-1:0] crc_fin; // Loaded ending address.
  logic [AW-1:0] crc_ptr; // Next word to fold in.
  logic [31:0] crc_val; // Running check-value.
  logic [31:0] crc_res; // Stored check-value.
  logic [31:0] next_crc; // Check-value with this word folded in.
  logic [15:0] next_rd_data; // Read data for this beat.
  logic [15:0] wd; // Write data shorthand.
  logic cmd_ok; // This write is a command, not data.

  assign wd = wr.data;
  // Data phases of multi-write sequences are never decoded as commands.
  assign cmd_ok = wr_valid && !prog_pend && !wbuf_arm && wbuf_cnt == 9'h000 &&
                  unl_cnt == 3'h0;
  assign next_crc = crc_step(crc_val, array_rdata);

  // ----------------------------------------------------------------
  // Mode sequencing.
  // ----------------------------------------------------------------
  // Keeps one active map; overlay entries only from read mode, status entry from any map.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mode <= FOMC_RD;
      ret_mode <= FOMC_RD;
      ovl_sec <= '0;
      status_cap <= 16'h0000;
    end else if (rd_req && mode == FOMC_STAT) begin
      mode <= ret_mode;
    end else if (cmd_ok) begin
      if (wd == `FOMC_CMD_EXIT) begin
        mode <= FOMC_RD;
      end else if (wd == `FOMC_CMD_STAT) begin
        status_cap <= status_in;
        ret_mode <= (mode == FOMC_STAT) ? ret_mode : mode;
        mode <= FOMC_STAT;
      end else if (wd == `FOMC_CMD_LEGEXIT &&
                   mode inside {FOMC_SSR, FOMC_CFG, FOMC_PWD, FOMC_PPB,
                                FOMC_LOCK, FOMC_DYB}) begin
        mode <= FOMC_RD;
      end else if (mode == FOMC_RD) begin
        ovl_sec <= sec(wr.addr);
        case (wd)
          `FOMC_CMD_ID: mode <= (wr.addr == `FOMC_ID_ADDR) ? FOMC_ID : FOMC_RD;
          `FOMC_CMD_SSR: mode <= FOMC_SSR;
          `FOMC_CMD_CFG: mode <= FOMC_CFG;
          `FOMC_CMD_PWD: mode <= FOMC_PWD;
          `FOMC_CMD_PPB: mode <= FOMC_PPB;
          `FOMC_CMD_LOCK: mode <= FOMC_LOCK;
          `FOMC_CMD_DYB: mode <= FOMC_DYB;
          `FOMC_CMD_ECC: mode <= FOMC_ECC;
          `FOMC_CMD_CRC: mode <= FOMC_CRC;
          default: mode <= FOMC_RD;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Protection registers and program sequences.
  // ----------------------------------------------------------------
  // Handles modified word programming, buffer writes and unlock.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prog_pend <= 1'b0;
      wbuf_arm <= 1'b0;
      wbuf_cnt <= 9'h000;
      unl_cnt <= 3'h0;
      unl_ok <= 1'b0;
      cfg_reg <= `FOMC_CFG_RST;
      pwd <= '{default: 16'h0000};
      persistent_sector_protect_bit <= '0;
      volatile_sector_protect_bit <= '0;
      lock <= `FOMC_LOCK_RST;
      ecc_sel <= 2'h0;
    end else if (prog_pend && wr_valid) begin
      prog_pend <= 1'b0;
      case (mode)
        FOMC_CFG: cfg_reg <= wd;
        FOMC_PWD: pwd[wr.addr[1:0]] <= wd;
        FOMC_PPB: persistent_sector_protect_bit[sec(wr.addr)] <= 1'b1;
        FOMC_LOCK: lock <= 1'b0;
        FOMC_DYB: volatile_sector_protect_bit[sec(wr.addr)] <= wd[0];
        default: prog_pend <= 1'b0;
      endcase
    end else if (wbuf_arm && wr_valid) begin
      wbuf_arm <= 1'b0;
      wbuf_cnt <= {1'b0, wd[7:0]} + 9'h001;
    end else if (wbuf_cnt != 9'h000 && wr_valid) begin
      wbuf_cnt <= wbuf_cnt - 9'h001;
    end else if (unl_cnt != 3'h0 && wr_valid) begin
      unl_cnt <= unl_cnt - 3'h1;
      unl_ok <= unl_ok && (wd == pwd[wr.addr[1:0]]);
      if (unl_cnt == 3'h1 && unl_ok && wd == pwd[wr.addr[1:0]]) begin
        lock <= 1'b0;
      end
    end else if (cmd_ok) begin
      if (wd == `FOMC_CMD_PROG && mode inside {FOMC_SSR, FOMC_CFG, FOMC_PWD,
          FOMC_PPB, FOMC_LOCK, FOMC_DYB}) begin
        prog_pend <= 1'b1;
      end else if (wd == `FOMC_CMD_WBUF && mode == FOMC_SSR) begin
        wbuf_arm <= 1'b1;
      end else if (wd == `FOMC_CMD_UNLOCK && mode == FOMC_PWD) begin
        unl_cnt <= 3'h4;
        unl_ok <= 1'b1;
      end else if (wd == `FOMC_CMD_PPBERASE && mode == FOMC_PPB) begin
        persistent_sector_protect_bit <= '0;
      end else if (mode == FOMC_ECC && wd == `FOMC_CMD_ECCSTAT) begin
        ecc_sel <= 2'h0;
      end else if (mode == FOMC_ECC && wd == `FOMC_CMD_TRAPLO) begin
        ecc_sel <= 2'h1;
      end else if (mode == FOMC_ECC && wd == `FOMC_CMD_TRAPHI) begin
        ecc_sel <= 2'h2;
      end else if (mode == FOMC_ECC && wd == `FOMC_CMD_ECCCNT) begin
        ecc_sel <= 2'h3;
      end
    end
  end

  // ----------------------------------------------------------------
  // Secure region write port.
  // ----------------------------------------------------------------
  // One pulse per accepted secure word or buffer word.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      aux_wr <= 1'b0;
      aux_waddr <= '0;
      aux_wdata <= 16'h0000;
    end else begin
      aux_wr <= wr_valid && mode == FOMC_SSR && (prog_pend || wbuf_cnt != 9'h000);
      aux_waddr <= wr.addr[SOFF-1:0];
      aux_wdata <= wd;
    end
  end

  // ----------------------------------------------------------------
  // CRC engine.
  // ----------------------------------------------------------------
  // Folds one array word per cycle while running and not suspended.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      crc_busy <= 1'b0;
      crc_susp <= 1'b0;
      crc_beg <= '0;
      crc_fin <= '0;
      crc_ptr <= '0;
      crc_val <= `FOMC_CRC_INIT;
      crc_res <= 32'h0000_0000;
    end else if (cmd_ok && mode == FOMC_CRC) begin
      if (wd == `FOMC_CMD_EXIT) begin
        crc_busy <= 1'b0;
        crc_susp <= 1'b0;
      end else if (crc_susp) begin
        crc_susp <= (wd != `FOMC_CMD_RESUME);
      end else if (wd == `FOMC_CMD_CRCBEG) begin
        crc_beg <= wr.addr;
      end else if (wd == `FOMC_CMD_CRCEND) begin
        crc_fin <= wr.addr;
        crc_ptr <= crc_beg;
        crc_val <= `FOMC_CRC_INIT;
        crc_busy <= 1'b1;
      end else if (wd == `FOMC_CMD_SUSP) begin
        crc_susp <= crc_busy;
      end
    end else if (crc_busy && !crc_susp) begin
      crc_val <= next_crc;
      crc_ptr <= crc_ptr + 1'b1;
      if (crc_ptr == crc_fin) begin
        crc_busy <= 1'b0;
        crc_res <= next_crc;
      end
    end
  end

  assign crc_result_low = crc_res[15:0];
  assign crc_result_high = crc_res[31:16];

  // ----------------------------------------------------------------
  // Read path.
  // ----------------------------------------------------------------
  // The engine owns the array port while it runs unsuspended.
  assign array_addr = (crc_busy && !crc_susp) ? crc_ptr : rd.addr;
  assign aux_addr = rd.addr[SOFF-1:0];
  assign aux_sel_id = (mode == FOMC_ID);
  assign ecc_hp_addr = rd.addr[AW-1:HPB];

  // Selects the data for this beat from the active map.
  always_comb begin
    next_rd_data = array_rdata;
    case (mode)
      FOMC_STAT: next_rd_data = rd.first ? status_cap : 16'h0000;
      FOMC_ID: if (sec(rd.addr) == ovl_sec) next_rd_data = aux_rdata;
      FOMC_SSR: begin
        if (sec(rd.addr) == ovl_sec) begin
          next_rd_data = (aux_addr < SOFF'(SSR_WORDS)) ? aux_rdata : 16'h0000;
        end
      end
      FOMC_CFG: next_rd_data = (rd.addr == `FOMC_CFG_ADDR) ? cfg_reg : 16'h0000;
      FOMC_PWD: next_rd_data = (rd.addr <= `FOMC_PWD_LAST) ? pwd[rd.addr[1:0]] : 16'h0000;
      FOMC_PPB: next_rd_data = {15'h0000, persistent_sector_protect_bit[sec(rd.addr)]};
      FOMC_LOCK: next_rd_data = {15'h0000, lock};
      FOMC_DYB: next_rd_data = {15'h0000, volatile_sector_protect_bit[sec(rd.addr)]};
      FOMC_ECC: begin
        case (ecc_sel)
          2'h1: next_rd_data = ecc_trap_lo;
          2'h2: next_rd_data = ecc_trap_hi;
          2'h3: next_rd_data = ecc_count;
          default: next_rd_data = {11'h000, ecc_status};
        endcase
      end
      FOMC_CRC: begin
        if (!crc_susp) next_rd_data = rd.addr[0] ? crc_result_high : crc_result_low;
      end
      default: next_rd_data = array_rdata;
    endcase
    if (stat_tail && !rd.first) next_rd_data = 16'h0000;
  end

  // Registers read answers and tracks the burst that carried status.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_valid <= 1'b0;
      rd_data <= 16'h0000;
      stat_tail <= 1'b0;
    end else begin
      rd_valid <= rd_req;
      if (rd_req) rd_data <= next_rd_data;
      if (rd_req && mode == FOMC_STAT) begin
        stat_tail <= 1'b1;
      end else if (rd_req && rd.first) begin
        stat_tail <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/fomc_overlay_properties.sv
// Concurrent checks on the overlay control ports.
`default_nettype none
`include "fomc_map.svh"
module fomc_overlay_props (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic wr_valid,
  input wire fomc_pkg::fomc_wr_s wr,
  input wire logic rd_req,
  input wire fomc_pkg::fomc_rd_s rd,
  input wire logic rd_valid,
  input wire logic [`FOMC_DW-1:0] rd_data,
  input wire logic [`FOMC_AW-1:0] array_addr,
  input wire logic [`FOMC_DW-1:0] array_rdata,
  input wire logic [`FOMC_DW-1:0] status_in,
  input wire logic [15:0] crc_result_low,
  input wire logic [15:0] crc_result_high,
  input wire logic crc_busy,
  input wire fomc_pkg::fomc_mode_e mode
);
  timeunit 1ns;
  timeprecision 1ps;
  import fomc_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Status word captured by the status command.
  logic [15:0] stat_q;
  // Map that was active before the status overlay.
  fomc_mode_e map_q;
  // Capture status on each status command issued outside the status overlay.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stat_q <= 16'h0000;
    end else if (wr_valid && wr.data == `FOMC_CMD_STAT && mode != FOMC_STAT) begin
      stat_q <= status_in;
    end
  end
  // Remember the last map that was not the status overlay.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      map_q <= FOMC_RD;
    end else if (mode != FOMC_STAT) begin
      map_q <= mode;
    end
  end
  a_id_entry: assert property (
    wr_valid && wr.data == `FOMC_CMD_ID && mode == FOMC_RD
    |=> mode == (($past(wr.addr) == `FOMC_ID_ADDR) ? FOMC_ID : FOMC_RD))
    else $error("identification entry gave the wrong map");
  a_common_exit: assert property (
    wr_valid && wr.data == `FOMC_CMD_EXIT |=> mode == FOMC_RD)
    else $error("common exit did not return to array reads");
  a_legacy_exit: assert property (
    wr_valid && wr.data == `FOMC_CMD_LEGEXIT
    && mode inside {FOMC_SSR, FOMC_CFG, FOMC_PWD, FOMC_PPB, FOMC_LOCK, FOMC_DYB}
    |=> mode == FOMC_RD)
    else $error("legacy exit did not return to array reads");
  a_status_read: assert property (
    mode == FOMC_STAT && rd_req && rd.first |=> mode == map_q && rd_data == stat_q)
    else $error("status read gave wrong data or map");
  a_read_answer: assert property (
    rd_req |=> rd_valid)
    else $error("read answer missing");
  a_valid_cause: assert property (
    rd_valid |-> $past(rd_req))
    else $error("read answer without request");
  a_array_read: assert property (
    mode == FOMC_RD && rd_req |-> array_addr == rd.addr ##1 rd_data == $past(array_rdata))
    else $error("array read path wrong");
  a_crc_halves: assert property (
    mode == FOMC_CRC && rd_req && !crc_busy
    |=> rd_data == ($past(rd.addr[0]) ? crc_result_high : crc_result_low))
    else $error("check value half wrong");
  a_crc_start: assert property (
    wr_valid && mode == FOMC_CRC && wr.data == `FOMC_CMD_CRCEND && !crc_busy |=> crc_busy)
    else $error("calculation did not start");
  a_result_hold: assert property (
    $changed({crc_result_high, crc_result_low}) |-> $fell(crc_busy))
    else $error("check value changed outside completion");
endmodule
bind fomc_overlay_ctrl fomc_overlay_props u_props (
  .clock, .arst_n, .wr_valid, .wr, .rd_req, .rd, .rd_valid, .rd_data, .array_addr,
  .array_rdata, .status_in, .crc_result_low, .crc_result_high, .crc_busy, .mode
);
`default_nettype wire

// File: bench/fomc_mem_model.sv
// Behavioural array, auxiliary memory, status and ECC sources.
`default_nettype none
`include "fomc_map.svh"
module fomc_mem_model (
  input wire logic [`FOMC_AW-1:0] array_addr,
  input wire logic [16:0] aux_addr,
  input wire logic aux_sel_id,
  output logic [`FOMC_DW-1:0] array_rdata,
  output logic [`FOMC_DW-1:0] aux_rdata,
  output logic [`FOMC_DW-1:0] status_in,
  output logic [4:0] ecc_status,
  output logic [`FOMC_DW-1:0] ecc_trap_lo,
  output logic [`FOMC_DW-1:0] ecc_trap_hi,
  output logic [`FOMC_DW-1:0] ecc_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // Array words follow the low 16 address bits, so words within one 64K span differ.
  assign array_rdata = array_addr[15:0] ^ 16'h5A5A;
  // Identification data and secure words carry a marker nibble.
  assign aux_rdata = {aux_sel_id ? 4'h1 : 4'h5, aux_addr[11:0]};
  assign status_in = 16'h0080;
  assign ecc_status = 5'h15;
  assign ecc_trap_lo = 16'hA1A1;
  assign ecc_trap_hi = 16'hA1A2;
  assign ecc_count = 16'hA1A3;
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench: host command and read sequences against the overlay control.
`default_nettype none
`include "fomc_map.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fomc_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic wr_valid = 1'b0;
  fomc_wr_s wr = '0;
  logic rd_req = 1'b0;
  fomc_rd_s rd = '0;
  logic rd_valid, crc_busy, aux_sel_id, aux_wr;
  logic [15:0] rd_data, array_rdata, status_in, aux_rdata, aux_wdata, ecc_trap_lo;
  logic [15:0] ecc_trap_hi, ecc_count, crc_result_low, crc_result_high;
  logic [24:0] array_addr;
  logic [16:0] aux_addr, aux_waddr;
  logic [20:0] ecc_hp_addr;
  logic [4:0] ecc_status;
  fomc_mode_e mode;
  int n_fail = 0;
  int n_tests = 0;
  always #25 clock = ~clock;
  fomc_overlay_ctrl u_dut (.clock, .arst_n, .wr_valid, .wr, .rd_req, .rd, .rd_valid,
    .rd_data, .array_addr, .array_rdata, .status_in, .aux_addr, .aux_sel_id, .aux_rdata,
    .aux_wr, .aux_waddr, .aux_wdata, .ecc_hp_addr, .ecc_status, .ecc_trap_lo,
    .ecc_trap_hi, .ecc_count, .crc_result_low, .crc_result_high, .crc_busy, .mode);
  fomc_mem_model u_mem (.array_addr, .aux_addr, .aux_sel_id, .array_rdata, .aux_rdata,
    .status_in, .ecc_status, .ecc_trap_lo, .ecc_trap_hi, .ecc_count);
  // Compare one value and count the outcome.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] e);
    n_tests++;
    if (seen !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, e, seen);
    end
  endtask
  // One host write, taken at the rising edge between two falling edges.
  task automatic wcmd(input logic [24:0] a, input logic [15:0] d);
    @(negedge clock);
    wr_valid = 1'b1;
    wr = '{addr: a, data: d};
    @(negedge clock);
    wr_valid = 1'b0;
  endtask
  // One read beat; the answer stands in the following cycle.
  task automatic rchk(input logic [24:0] a, input logic f, input logic [15:0] e,
                      input logic [15:0] m = 16'hFFFF);
    @(negedge clock);
    rd_req = 1'b1;
    rd = '{addr: a, first: f};
    @(negedge clock);
    rd_req = 1'b0;
    chk("rd_valid", rd_valid, 1'b1);
    chk("rd_data", rd_data & m, e);
  endtask
  task automatic do_reset();
    arst_n = 1'b0;
    repeat (16) @(negedge clock);
    arst_n = 1'b1;
  endtask
  task automatic wait_crc();
    for (int i = 0; i < 200 && crc_busy === 1'b1; i++) begin
      @(negedge clock);
    end
    chk("crc_busy", crc_busy, 1'b0);
  endtask
  function automatic logic [15:0] mem(input logic [24:0] a);
    return a[15:0] ^ 16'h5A5A;
  endfunction
  // Reference check value, most significant bit of each word first.
  function automatic logic [31:0] crc(input logic [24:0] s, input logic [24:0] e);
    logic [31:0] c;
    logic [15:0] w;
    c = `FOMC_CRC_INIT;
    for (logic [24:0] a = s; a <= e; a++) begin
      w = mem(a);
      for (int i = 15; i >= 0; i--) begin
        c = {c[30:0], 1'b0} ^ ((c[31] ^ w[i]) ? `FOMC_CRC_POLY : 32'h0000_0000);
      end
    end
    return c;
  endfunction
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Watchdog: the sequence needs well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    conclude();
  end
  initial begin
    logic [31:0] x;
    do_reset();
    chk("mode", mode, FOMC_RD);
    chk("crc", {crc_result_high, crc_result_low}, 32'h0000_0000);
    wcmd(25'h000_0556, `FOMC_CMD_ID);
    chk("mode", mode, FOMC_RD);
    wcmd(`FOMC_ID_ADDR, `FOMC_CMD_ID);
    chk("mode", mode, FOMC_ID);
    chk("aux_sel_id", aux_sel_id, 1'b1);
    rchk(25'h000_0012, 1'b1, 16'h1012);
    wcmd(25'h0, `FOMC_CMD_EXIT);
    rchk(25'h000_0012, 1'b1, mem(25'h12));
    wcmd(25'h0, `FOMC_CMD_CFG);
    // status read follows its command directly.
    wcmd(25'h0, `FOMC_CMD_STAT);
    chk("mode", mode, FOMC_STAT);
    rchk(25'h0, 1'b1, 16'h0080);
    chk("mode", mode, FOMC_CFG);
    rchk(25'h0, 1'b0, 16'h0000);
    rchk(25'h0, 1'b1, `FOMC_CFG_RST);
    wcmd(25'h0, `FOMC_CMD_PROG);
    wcmd(25'h0, 16'h1234);
    rchk(25'h0, 1'b1, 16'h1234);
    wcmd(25'h0, `FOMC_CMD_LEGEXIT);
    chk("mode", mode, FOMC_RD);
    wcmd(25'h0, `FOMC_CMD_PWD);
    wcmd(25'h0, `FOMC_CMD_PROG);
    wcmd(25'h2, 16'hBEEF);
    rchk(25'h2, 1'b1, 16'hBEEF);
    rchk(25'h4, 1'b1, 16'h0000);
    wcmd(25'h0, `FOMC_CMD_UNLOCK);
    for (int i = 0; i < 4; i++) begin
      wcmd(25'(i), (i == 2) ? 16'hBEEF : 16'h0000);
    end
    wcmd(25'h0, `FOMC_CMD_EXIT);
    wcmd(25'h0, `FOMC_CMD_LOCK);
    rchk(25'h000_0123, 1'b1, 16'h0000, 16'h0001);
    do_reset();
    chk("mode", mode, FOMC_RD);
    wcmd(25'h0, `FOMC_CMD_PPB);
    wcmd(25'h0, `FOMC_CMD_PROG);
    wcmd(25'h006_0005, 16'h0000);
    rchk(25'h007_FFFF, 1'b1, 16'h0001, 16'h0001);
    rchk(25'h008_0000, 1'b1, 16'h0000, 16'h0001);
    wcmd(25'h0, `FOMC_CMD_PPBERASE);
    rchk(25'h006_0000, 1'b1, 16'h0000, 16'h0001);
    wcmd(25'h0, `FOMC_CMD_EXIT);
    wcmd(25'h0, `FOMC_CMD_LOCK);
    rchk(25'h001_0000, 1'b1, 16'h0001, 16'h0001);
    wcmd(25'h0, `FOMC_CMD_PROG);
    wcmd(25'h0, 16'h0000);
    rchk(25'h0, 1'b1, 16'h0000, 16'h0001);
    wcmd(25'h0, `FOMC_CMD_LEGEXIT);
    wcmd(25'h0, `FOMC_CMD_DYB);
    for (int i = 1; i >= 0; i--) begin
      wcmd(25'h0, `FOMC_CMD_PROG);
      wcmd(25'h004_0000, 16'(i));
      rchk(25'h005_0001, 1'b1, 16'(i), 16'h0001);
    end
    wcmd(25'h0, `FOMC_CMD_LEGEXIT);
    wcmd(25'h0, `FOMC_CMD_ECC);
    rchk(25'h000_0237, 1'b1, 16'h0015);
    chk("ecc_hp_addr", ecc_hp_addr, 21'h00_0023);
    for (int i = 0; i < 3; i++) begin
      wcmd(25'h0, `FOMC_CMD_TRAPLO + 16'(i));
      rchk(25'h0, 1'b1, 16'hA1A1 + 16'(i));
    end
    wcmd(25'h0, `FOMC_CMD_ECCSTAT);
    rchk(25'h000_0237, 1'b1, 16'h0015);
    wcmd(25'h0, `FOMC_CMD_EXIT);
    chk("mode", mode, FOMC_RD);
    wcmd(25'h008_0000, `FOMC_CMD_SSR);
    rchk(25'h008_0010, 1'b1, 16'h5010);
    rchk(25'h008_0400, 1'b1, 16'h0000);
    rchk(25'h00A_0007, 1'b1, mem(25'h00A_0007));
    chk("mode", mode, FOMC_SSR);
    wcmd(25'h0, `FOMC_CMD_PROG);
    wcmd(25'h008_0003, 16'h7777);
    chk("aux_wr", {aux_wr, aux_waddr, aux_wdata}, {1'b1, 17'h0_0003, 16'h7777});
    wcmd(25'h0, `FOMC_CMD_WBUF);
    wcmd(25'h0, 16'h0000);
    wcmd(25'h008_0005, 16'h6666);
    chk("aux_wr", {aux_wr, aux_waddr, aux_wdata}, {1'b1, 17'h0_0005, 16'h6666});
    wcmd(25'h0, `FOMC_CMD_LEGEXIT);
    chk("mode", mode, FOMC_RD);
    wcmd(25'h0, `FOMC_CMD_CRC);
    wcmd(25'h010, `FOMC_CMD_CRCBEG);
    wcmd(25'h013, `FOMC_CMD_CRCEND);
    chk("crc_busy", crc_busy, 1'b1);
    wait_crc();
    x = crc(25'h010, 25'h013);
    chk("crc", {crc_result_high, crc_result_low}, x);
    rchk(25'h0, 1'b1, x[15:0]);
    rchk(25'h1, 1'b1, x[31:16]);
    wcmd(25'h000, `FOMC_CMD_CRCBEG);
    wcmd(25'h040, `FOMC_CMD_CRCEND);
    wcmd(25'h0, `FOMC_CMD_SUSP);
    rchk(25'h000_0007, 1'b1, mem(25'h7));
    wcmd(25'h020, `FOMC_CMD_CRCEND);
    wcmd(25'h0, `FOMC_CMD_RESUME);
    wait_crc();
    chk("crc", {crc_result_high, crc_result_low}, crc(25'h000, 25'h040));
    wcmd(25'h0, `FOMC_CMD_EXIT);
    chk("mode", mode, FOMC_RD);
    conclude();
  end
endmodule
`default_nettype wire
